// [cbac_ctrl.sv]
// command register, power controls and register readback
// assumes the command executor pulses cmd_done when a command ends
`timescale 1ns/100ps
module cbac_ctrl (
  input  wire logic                clk,
  input  wire logic                reset,
  input  wire cbac_pkg::cbac_req_s req,
  input  wire logic                cmd_done,
  input  wire logic                wake,
  output      logic [7:0]          rdata,
  output      logic                rd_hit,
  output      logic                cmd_start,
  output      logic [4:0]          cmd_code,
  output      logic                exec_busy,
  output      logic                power_down,
  output      logic                receiver_off,
  output      logic                transmitter_off,
  output      logic                bus_owned_by_host,
  output      logic                bus_owned_by_secure_module,
  output      logic                port_spi_en,
  output      logic                port_lv_two_wire_en,
  output      logic                port_i2c_en
);

  // ************************************************************
  // decode helpers
  // ************************************************************
  function automatic logic hits(input cbac_pkg::cbac_req_s r,
                                input logic [6:0]          a);
    hits = (r.addr == a);
  endfunction

  cbac_pkg::cbac_own_s  own;
  cbac_pkg::cbac_exec_e exec;
  cbac_pkg::cbac_exec_e next_exec;
  logic                 wr_cmd;
  logic                 wr_own;
  logic [4:0]           next_cmd_code;
  logic                 next_cmd_start;
  logic                 next_power_down;
  logic                 next_radio_off;
  logic                 radio_off;
  logic [7:0]           next_rdata;
  logic                 next_rd_hit;
  logic                 next_spi;
  logic                 next_lv;
  logic                 next_i2c;

  assign wr_cmd = req.wr && hits(req, cbac_pkg::CMD_REG_ADDR);
  assign wr_own = req.wr && hits(req, cbac_pkg::OWN_REG_ADDR);

  cbac_own_guard u_own_guard (
    .clk   (clk),
    .reset (reset),
    .req   (req),
    .own   (own)
  );

  // ************************************************************
  // command and power
  // ************************************************************
  always_comb begin
    next_exec       = exec;
    next_cmd_code   = cmd_code;
    next_cmd_start  = 1'b0;
    next_power_down = power_down;
    next_radio_off  = radio_off;
    // a host write in the finishing cycle wins: the new command runs
    if (wr_cmd) begin
      next_cmd_code   = req.wdata[cbac_pkg::CMD_MSB:cbac_pkg::CMD_LSB];
      next_cmd_start  = 1'b1;
      next_power_down = req.wdata[cbac_pkg::POS_POWER_DOWN];
      next_radio_off  = req.wdata[cbac_pkg::POS_RADIO_OFF];
      next_exec = (next_cmd_code == cbac_pkg::CMD_IDLE) ?
                  cbac_pkg::EXEC_IDLE : cbac_pkg::EXEC_BUSY;
    end else begin
      unique case (exec)
        cbac_pkg::EXEC_IDLE: begin
          next_exec = cbac_pkg::EXEC_IDLE;
        end
        cbac_pkg::EXEC_BUSY: begin
          if (cmd_done) begin
            next_cmd_code = cbac_pkg::CMD_IDLE;
            next_exec     = cbac_pkg::EXEC_IDLE;
          end
        end
        default: begin
          next_exec = cbac_pkg::EXEC_IDLE;
        end
      endcase
      // the wake event is the device's own write of the standby bit
      if (wake) begin
        next_power_down = 1'b0;
      end
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      exec       <= cbac_pkg::EXEC_IDLE;
      cmd_code   <= cbac_pkg::CMD_IDLE;
      cmd_start  <= 1'b0;
      power_down <= cbac_pkg::POWER_DOWN_INIT;
      radio_off  <= cbac_pkg::RADIO_OFF_INIT;
    end else begin
      exec       <= next_exec;
      cmd_code   <= next_cmd_code;
      cmd_start  <= next_cmd_start;
      power_down <= next_power_down;
      radio_off  <= next_radio_off;
    end
  end

  // ************************************************************
  // outputs and readback
  // ************************************************************
  // port enables lag the field by one clock so each port enable is a flop
  always_comb begin
    next_spi    = (own.port == cbac_pkg::PORT_SPI);
    next_lv     = (own.port == cbac_pkg::PORT_LV2W);
    next_i2c    = (own.port == cbac_pkg::PORT_I2C);
    next_rdata  = rdata;
    next_rd_hit = 1'b0;
    if (req.rd) begin
      next_rd_hit = hits(req, cbac_pkg::CMD_REG_ADDR) ||
                    hits(req, cbac_pkg::OWN_REG_ADDR);
      if (hits(req, cbac_pkg::CMD_REG_ADDR)) begin
        next_rdata = {power_down, radio_off, 1'b0, cmd_code};
      end else if (hits(req, cbac_pkg::OWN_REG_ADDR)) begin
        next_rdata = {own.unlock, own.host, own.secure, 1'b0,
                      own.port, 2'h0};
      end else begin
        next_rdata = cbac_pkg::RDATA_INIT;
      end
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      rdata               <= cbac_pkg::RDATA_INIT;
      rd_hit              <= 1'b0;
      port_spi_en         <= 1'b0;
      port_lv_two_wire_en <= 1'b0;
      port_i2c_en         <= 1'b0;
    end else begin
      rdata               <= next_rdata;
      rd_hit              <= next_rd_hit;
      port_spi_en         <= next_spi;
      port_lv_two_wire_en <= next_lv;
      port_i2c_en         <= next_i2c;
    end
  end

  assign exec_busy                  = (exec == cbac_pkg::EXEC_BUSY);
  assign receiver_off               = radio_off;
  assign transmitter_off            = radio_off;
  assign bus_owned_by_host          = own.host;
  assign bus_owned_by_secure_module = own.secure;

  // ************************************************************
  // assertions
  // ************************************************************
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);

  AST_POWER_DOWN_WRITE: assert property (
    wr_cmd |=> power_down == $past(req.wdata[7]))
    else $error("power-down does not follow the command write");

  AST_RADIO_OFF_BOTH: assert property (
    wr_cmd |=> receiver_off == $past(req.wdata[6]) &&
               transmitter_off == receiver_off && power_down ==
               $past(req.wdata[7]))
    else $error("radio power-down wrong");

  // a back-to-back command write legally restarts the pulse
  AST_COMMAND_LAUNCH: assert property (
    wr_cmd |=> cmd_start && cmd_code == $past(req.wdata[4:0]) ##1
      (!cmd_start || $past(wr_cmd)))
    else $error("command write did not launch exactly once");

  AST_COMMAND_FINISH: assert property (
    (exec_busy && cmd_done && !wr_cmd) |=> cmd_code == 5'h00 && !exec_busy)
    else $error("finished command not cleared");

  AST_UNLOCK_SET: assert property (
    (wr_own && req.wdata[7] && !own.unlock) |=> own.unlock)
    else $error("unlock write ignored");

  AST_UNLOCK_ONE_SHOT: assert property (
    (req.wr && own.unlock) |=> !own.unlock)
    else $error("unlock survived a write");

  AST_HOST_GRANT: assert property (
    (wr_own && own.unlock && req.wdata[6:5] == 2'h2) |=>
      bus_owned_by_host && !bus_owned_by_secure_module)
    else $error("host grant failed");

  AST_SECURE_GRANT: assert property (
    (wr_own && own.unlock && req.wdata[6:5] == 2'h1) |=>
      bus_owned_by_secure_module && !bus_owned_by_host)
    else $error("secure module grant failed");

  AST_NEVER_BOTH_OWNERS: assert property (
    !(bus_owned_by_host && bus_owned_by_secure_module))
    else $error("both owners granted");

  AST_LOCKED_HOLDS: assert property (
    (wr_own && (!own.unlock || req.wdata[6:5] == 2'h3)) |=>
      $stable(bus_owned_by_host) && $stable(bus_owned_by_secure_module))
    else $error("ownership changed without a valid unlock");

  AST_PORT_SELECT: assert property (
    wr_own |=> ##1 port_spi_en == ($past(req.wdata[3:2], 2) == 2'h1) &&
      port_lv_two_wire_en == ($past(req.wdata[3:2], 2) == 2'h2) &&
      port_i2c_en == ($past(req.wdata[3:2], 2) == 2'h3))
    else $error("port select mismatch");

  AST_RESERVED_ZERO: assert property (
    (req.rd && hits(req, cbac_pkg::OWN_REG_ADDR)) |=>
      rd_hit && rdata[4] == 1'b0 && rdata[1:0] == 2'h0)
    else $error("reserved bits read non-zero");

  COV_UNLOCK_THEN_HOST: cover property (
    (wr_own && req.wdata[7]) ##1 (wr_own && req.wdata[6:5] == 2'h2));
  COV_COMMAND_RUN: cover property (
    wr_cmd ##[1:20] (exec_busy && cmd_done));
  COV_REFUSED_BOTH: cover property (
    wr_own && own.unlock && req.wdata[6:5] == 2'h3);

endmodule // cbac_ctrl

// [cbac_ctrl_tb_top.sv]
// bench for cbac_ctrl: random and corner register traffic
// assumes the executor model drives cmd_done
`timescale 1ns/100ps
module cbac_ctrl_tb_top;
  logic                clk = 1'b0;
  logic                reset = 1'b1;
  logic                wake = 1'b0;
  logic [3:0]          dly = 4'h1;
  cbac_pkg::cbac_req_s req = '0;
  logic                cmd_done, rd_hit, cmd_start, exec_busy;
  logic                power_down, rx_off, tx_off, host, sec;
  logic                en_spi, en_lv, en_i2c, pd, ro;
  logic [7:0]          rdata, own_sh, d;
  logic [4:0]          cmd_code, code;
  logic [7:0]          pat [10] = '{8'h80, 8'h44, 8'h20, 8'h80, 8'h60,
                                    8'h80, 8'h28, 8'h80, 8'h6C, 8'h08};
  int                  n_errors = 0;
  int                  total_checks = 0;
  int                  cycles = 0;
  int                  seed = 32'h3034CEFA;

  always #2 clk = ~clk;

  cbac_ctrl u_dut (.clk(clk), .reset(reset), .req(req),
    .cmd_done(cmd_done), .wake(wake), .rdata(rdata), .rd_hit(rd_hit),
    .cmd_start(cmd_start), .cmd_code(cmd_code), .exec_busy(exec_busy),
    .power_down(power_down), .receiver_off(rx_off),
    .transmitter_off(tx_off), .bus_owned_by_host(host),
    .bus_owned_by_secure_module(sec), .port_spi_en(en_spi),
    .port_lv_two_wire_en(en_lv), .port_i2c_en(en_i2c));

  cbac_exec_model u_exec (.clk(clk), .reset(reset),
    .exec_busy(exec_busy), .dly(dly), .cmd_done(cmd_done));

  // ****************************************
  // checks and bus cycles
  // ****************************************
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    total_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [6:0] a, input logic [7:0] dat);
    @(negedge clk);
    req = '{wr: 1'b1, rd: 1'b0, addr: a, wdata: dat};
    @(negedge clk);
    req = '0;
  endtask

  task automatic rd(input logic [6:0] a, input logic [7:0] e, input hit);
    @(negedge clk);
    req = '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
    @(negedge clk);
    req = '0;
    chk(rdata, e);
    chk({7'h00, rd_hit}, {7'h00, hit});
  endtask

  // readback of the ownership register after one write
  function automatic logic [7:0] own_exp(logic [7:0] o, logic [7:0] v);
    logic [7:0] e;
    e = {1'b0, o[6:5], 1'b0, v[3:2], 2'h0};
    if (o[7] && v[6:5] != 2'h3) e[6:5] = v[6:5];
    if (!o[7] && v[7]) e[7] = 1'b1;
    return e;
  endfunction

  task automatic wown(input logic [7:0] v);
    wr(7'h01, v);
    own_sh = own_exp(own_sh, v);
    chk({6'h00, host, sec}, {6'h00, own_sh[6:5]});
    @(negedge clk);
    chk({5'h00, en_i2c, en_lv, en_spi},
        {5'h00, own_sh[3:2] == 2'h3, own_sh[3:2] == 2'h2,
         own_sh[3:2] == 2'h1});
    rd(7'h01, own_sh, 1'b1);
  endtask

  task automatic stop_test;
    if (n_errors == 0 && total_checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  always @(posedge clk) begin
    cycles++;
    if (cycles == 20000) begin
      n_errors++;
      stop_test;
    end
  end

  // ****************************************
  // scenarios
  // ****************************************
  initial begin
    own_sh = 8'h00;
    repeat (5) @(posedge clk);
    @(negedge clk);
    reset = 1'b0;
    rd(7'h00, 8'h00, 1'b1);
    rd(7'h01, 8'h00, 1'b1);
    foreach (pat[i]) wown(pat[i]);
    wown(8'h80);
    wr(7'h23, 8'h00);
    own_sh[7] = 1'b0;
    rd(7'h01, own_sh, 1'b1);
    rd(7'h23, 8'h00, 1'b0);
    for (int i = 0; i < 30; i++) begin
      d = $random(seed);
      d = d & 8'hEC;
      if (d[6:5] == 2'h3) d[6] = 1'b0;
      if (i[0]) wown(8'h80);
      wown(d);
    end
    for (int i = 0; i < 16; i++) begin
      code = $random(seed);
      dly = $random(seed);
      pd = $random(seed);
      ro = $random(seed);
      wr(7'h00, {pd, ro, 1'b0, code});
      own_sh[7] = 1'b0;
      chk({7'h00, cmd_start}, 8'h01);
      chk({3'h0, cmd_code}, {3'h0, code});
      chk({6'h00, exec_busy, power_down}, {6'h00, code != 5'h00, pd});
      chk({6'h00, rx_off, tx_off}, {6'h00, ro, ro});
      for (int k = 0; k < 20 && exec_busy === 1'b1; k++) @(negedge clk);
      chk({2'h0, exec_busy, cmd_code}, 8'h00);
      rd(7'h00, {pd, ro, 6'h00}, 1'b1);
      chk({7'h00, cmd_start}, 8'h00);
    end
    rd(7'h01, own_sh, 1'b1);
    // power down for sure first, so the wake check can fail
    wr(7'h00, 8'hC0);
    chk({6'h00, power_down, rx_off}, 8'h03);
    @(negedge clk);
    wake = 1'b1;
    @(negedge clk);
    wake = 1'b0;
    chk({6'h00, power_down, rx_off}, 8'h01);
    stop_test;
  end
endmodule // cbac_ctrl_tb_top

// [cbac_exec_model.sv]
// command executor model: ends each command after a chosen delay
// assumes exec_busy from the block, inputs sampled on falling edges
`timescale 1ns/100ps
module cbac_exec_model (
  input  wire logic       clk,
  input  wire logic       reset,
  input  wire logic       exec_busy,
  input  wire logic [3:0] dly,
  output      logic       cmd_done
);
  logic [3:0] cnt;

  // ****************************************
  // finish pulse
  // ****************************************
  // one-cycle pulse only while busy, so a stale done never leaks out
  always @(negedge clk or posedge reset) begin
    if (reset) begin
      cnt      <= 4'h0;
      cmd_done <= 1'b0;
    end else begin
      cmd_done <= 1'b0;
      if (exec_busy && !cmd_done) begin
        if (cnt >= dly) begin
          cmd_done <= 1'b1;
          cnt      <= 4'h0;
        end else begin
          cnt <= cnt + 4'h1;
        end
      end else begin
        cnt <= 4'h0;
      end
    end
  end
endmodule // cbac_exec_model

// [cbac_own_guard.sv]
// ownership register with its one-shot unlock guard
// assumes at most one register access per clock
`timescale 1ns/100ps
module cbac_own_guard (
  input  wire logic               clk,
  input  wire logic               reset,
  input  wire cbac_pkg::cbac_req_s req,
  output      cbac_pkg::cbac_own_s own
);

  cbac_pkg::cbac_own_s next_own;
  logic                wr_own;
  logic                ask_host;
  logic                ask_secure;

  assign wr_own     = req.wr && (req.addr == cbac_pkg::OWN_REG_ADDR);
  assign ask_host   = req.wdata[cbac_pkg::POS_HOST];
  assign ask_secure = req.wdata[cbac_pkg::POS_SECURE];

  // ************************************************************
  // next state
  // ************************************************************
  always_comb begin
    next_own = own;
    if (req.wr) begin
      // any write, to any address, spends the unlock
      if (own.unlock) begin
        next_own.unlock = 1'b0;
      end else if (wr_own && req.wdata[cbac_pkg::POS_UNLOCK]) begin
        next_own.unlock = 1'b1;
      end
    end
    if (wr_own) begin
      next_own.port = cbac_pkg::cbac_port_e'(
        req.wdata[cbac_pkg::PORT_MSB:cbac_pkg::PORT_LSB]);
      // both asked at once is refused whole, not half applied
      if (own.unlock && !(ask_host && ask_secure)) begin
        next_own.host   = ask_host;
        next_own.secure = ask_secure;
      end
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      own.unlock <= cbac_pkg::UNLOCK_INIT;
      own.host   <= cbac_pkg::HOST_INIT;
      own.secure <= cbac_pkg::SECURE_INIT;
      own.port   <= cbac_pkg::PORT_OFF;
    end else begin
      own <= next_own;
    end
  end

endmodule // cbac_own_guard

// [cbac_pkg.sv]
// command and bus access control: shared constants and types
// assumes one 250 MHz clock and a synchronous register access port
package cbac_pkg;

  // ************************************************************
  // widths and addresses
  // ************************************************************
  localparam int         ADDR_W       = 7;
  localparam int         DATA_W       = 8;
  localparam int         CMD_W        = 5;
  localparam logic [6:0] CMD_REG_ADDR = 7'h00;
  localparam logic [6:0] OWN_REG_ADDR = 7'h01;

  // ************************************************************
  // field positions
  // ************************************************************
  localparam int POS_POWER_DOWN = 7;
  localparam int POS_RADIO_OFF  = 6;
  localparam int CMD_LSB        = 0;
  localparam int CMD_MSB        = 4;
  localparam int POS_UNLOCK     = 7;
  localparam int POS_HOST       = 6;
  localparam int POS_SECURE     = 5;
  localparam int PORT_LSB       = 2;
  localparam int PORT_MSB       = 3;

  // ************************************************************
  // values after reset
  // ************************************************************
  localparam logic [4:0] CMD_IDLE        = 5'h00;
  localparam logic       POWER_DOWN_INIT = 1'h0;
  localparam logic       RADIO_OFF_INIT  = 1'h0;
  localparam logic       UNLOCK_INIT     = 1'h0;
  localparam logic       HOST_INIT       = 1'h0;
  localparam logic       SECURE_INIT     = 1'h0;
  localparam logic [7:0] RDATA_INIT      = 8'h00;

  // ************************************************************
  // types
  // ************************************************************
  typedef enum logic [1:0] {
    PORT_OFF  = 2'h0,
    PORT_SPI  = 2'h1,
    PORT_LV2W = 2'h2,
    PORT_I2C  = 2'h3
  } cbac_port_e;

  typedef enum logic [1:0] {
    EXEC_IDLE = 2'b01,
    EXEC_BUSY = 2'b10
  } cbac_exec_e;

  typedef struct packed {
    logic             wr;
    logic             rd;
    logic [6:0]       addr;
    logic [7:0]       wdata;
  } cbac_req_s;

  typedef struct packed {
    logic             unlock;
    logic             host;
    logic             secure;
    cbac_port_e       port;
  } cbac_own_s;

endpackage
